// ### core/ppo_pin_cell.sv
// per-pin override and input gating network of the port
`timescale 1ns/100ps
module ppo_pin_cell #(
  parameter int WIDTH = 8
) (
  input wire logic rst_i,
  input wire logic sleep_clamp_i,
  input wire logic global_pullup_disable_i,
  input wire logic [WIDTH-1:0] pin_direction_bit_i,
  input wire logic [WIDTH-1:0] pin_output_latch_bit_i,
  input wire logic [WIDTH-1:0] ext_int_enable_i,
  input wire ppo_pkg::ppo_pin_ovr_t [WIDTH-1:0] ovr_i,
  input wire logic [WIDTH-1:0] pad_i,
  output logic [WIDTH-1:0] drive_en_o,
  output logic [WIDTH-1:0] drive_val_o,
  output logic [WIDTH-1:0] pullup_o,
  output logic [WIDTH-1:0] raw_digital_input_o
);

  logic [WIDTH-1:0] pu_plain;
  logic [WIDTH-1:0] in_en;

  always_comb begin
    // {dir, latch, pud} == 3'b010 turns the pull-up on
    pu_plain = ~pin_direction_bit_i & pin_output_latch_bit_i & {WIDTH{~global_pullup_disable_i}};
    for (int i = 0; i < WIDTH; i++) begin
      if (ovr_i[i].pullup_override_enable) begin
        pullup_o[i] = ovr_i[i].pullup_override_value;
      end else begin
        pullup_o[i] = pu_plain[i];
      end
      if (ovr_i[i].direction_override_enable) begin
        drive_en_o[i] = ovr_i[i].direction_override_value;
      end else begin
        drive_en_o[i] = pin_direction_bit_i[i];
      end
      if (ovr_i[i].out_value_override_enable) begin
        drive_val_o[i] = ovr_i[i].out_value_override_value;
      end else begin
        drive_val_o[i] = pin_output_latch_bit_i[i];
      end
      if (ovr_i[i].input_enable_override_enable) begin
        in_en[i] = ovr_i[i].input_enable_override_value;
      end else begin
        // sleep clamps unless the pin's external interrupt is enabled; reset keeps inputs live
        in_en[i] = rst_i | ~(sleep_clamp_i & ~ext_int_enable_i[i]);
      end
      // clamp to ground ahead of the schmitt trigger
      raw_digital_input_o[i] = pad_i[i] & in_en[i];
    end
  end

endmodule

// ### core/ppo_pkg.sv
// constants and carrier types for the port pin override logic
package ppo_pkg;

  // ****************************************
  // register bus
  // ****************************************
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int PORT_W_MAX = 8;

  localparam logic [2:0] OFS_DIR = 3'h0;
  localparam logic [2:0] OFS_LATCH = 3'h1;
  localparam logic [2:0] OFS_SAMPLE = 3'h2;
  localparam logic [2:0] OFS_MISC = 3'h3;
  localparam logic [2:0] OFS_SENSE = 3'h4;
  localparam logic [2:0] OFS_IRQ_STAT = 3'h5;
  localparam logic [2:0] OFS_IRQ_MASK = 3'h6;

  // ****************************************
  // misc_function_control layout
  // ****************************************
  localparam int MISC_PUD_BIT = 2;
  localparam int MISC_RSVD_BIT = 4;
  localparam logic [7:0] MISC_RESET = 8'h00;
  localparam logic [7:0] MISC_WMASK = 8'hEF;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] DIR_RESET = 8'h00;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [7:0] SENSE_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] RDATA_IDLE = 8'h00;

  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic pullup_override_enable;
    logic pullup_override_value;
    logic direction_override_enable;
    logic direction_override_value;
    logic out_value_override_enable;
    logic out_value_override_value;
    logic input_enable_override_enable;
    logic input_enable_override_value;
  } ppo_pin_ovr_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } ppo_bus_req_t;

endpackage

// ### core/ppo_port.sv
// port pin override logic: registers, pad control, input sampling, pin interrupts
`timescale 1ns/100ps
module ppo_port #(
  parameter int WIDTH = 8
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire ppo_pkg::ppo_bus_req_t bus_i,
  output logic [ppo_pkg::DATA_W-1:0] rdata_o,
  input wire logic sleep_clamp_i,
  input wire ppo_pkg::ppo_pin_ovr_t [WIDTH-1:0] ovr_i,
  input wire logic [WIDTH-1:0] pad_i,
  output logic [WIDTH-1:0] pad_out_o,
  output logic [WIDTH-1:0] pad_oe_o,
  output logic [WIDTH-1:0] pullup_en_o,
  output logic [WIDTH-1:0] raw_digital_input_o,
  output logic [WIDTH-1:0] analog_pad_path_o,
  output logic [ppo_pkg::DATA_W-1:0] misc_function_control_o,
  output logic irq_o
);

  // ****************************************
  // elaboration check
  // ****************************************
  if (WIDTH < 1 || WIDTH > ppo_pkg::PORT_W_MAX) begin : g_bad_width
    $error("ppo_port: WIDTH must lie between 1 and 8");
  end

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [WIDTH-1:0] dir;
    logic [WIDTH-1:0] latch;
    logic [WIDTH-1:0] sync1;
    logic [WIDTH-1:0] sync2;
    logic [WIDTH-1:0] sync3;
    logic [WIDTH-1:0] sample;
    logic [WIDTH-1:0] sense;
    logic [WIDTH-1:0] stat;
    logic [WIDTH-1:0] mask;
    logic [WIDTH-1:0] oe;
    logic [WIDTH-1:0] out;
    logic [WIDTH-1:0] pu;
    logic [ppo_pkg::DATA_W-1:0] misc;
    logic [ppo_pkg::DATA_W-1:0] rdata;
    logic irq;
  } ppo_state_t;

  ppo_state_t state_r;
  ppo_state_t state_nxt;

  logic [WIDTH-1:0] cell_oe;
  logic [WIDTH-1:0] cell_out;
  logic [WIDTH-1:0] cell_pu;
  logic [WIDTH-1:0] cell_raw;

  function automatic logic [ppo_pkg::DATA_W-1:0] widen(input logic [WIDTH-1:0] v);
    widen = ppo_pkg::DATA_W'(v);
  endfunction

  function automatic logic [WIDTH-1:0] narrow(input logic [ppo_pkg::DATA_W-1:0] v);
    narrow = v[WIDTH-1:0];
  endfunction

  // ****************************************
  // pad cell network
  // ****************************************
  ppo_pin_cell #(
    .WIDTH(WIDTH)
  ) u_cell (
    .rst_i(rst_i),
    .sleep_clamp_i(sleep_clamp_i),
    .global_pullup_disable_i(state_r.misc[ppo_pkg::MISC_PUD_BIT]),
    .pin_direction_bit_i(state_r.dir),
    .pin_output_latch_bit_i(state_r.latch),
    .ext_int_enable_i(state_r.mask),
    .ovr_i(ovr_i),
    .pad_i(pad_i),
    .drive_en_o(cell_oe),
    .drive_val_o(cell_out),
    .pullup_o(cell_pu),
    .raw_digital_input_o(cell_raw)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic [WIDTH-1:0] agree;
    logic [WIDTH-1:0] edge_evt;
    logic [WIDTH-1:0] clr;
    agree = '0;
    edge_evt = '0;
    clr = '0;
    state_nxt = state_r;
    if (ce_i) begin
      // three-stage synchroniser; a change counts once stages two and three agree
      state_nxt.sync1 = cell_raw;
      state_nxt.sync2 = state_r.sync1;
      state_nxt.sync3 = state_r.sync2;
      agree = ~(state_r.sync2 ^ state_r.sync3);
      state_nxt.sample = (state_r.sample & ~agree) | (state_r.sync3 & agree);
      // flags set on any sampled change of edge-sensed pins, enabled or not;
      // leaving a clamping sleep with the pin high gives the 0->1 change
      edge_evt = (state_nxt.sample ^ state_r.sample) & state_r.sense;

      if (bus_i.wr) begin
        if (bus_i.addr == ppo_pkg::OFS_DIR) begin
          state_nxt.dir = narrow(bus_i.wdata);
        end else if (bus_i.addr == ppo_pkg::OFS_LATCH) begin
          state_nxt.latch = narrow(bus_i.wdata);
        end else if (bus_i.addr == ppo_pkg::OFS_MISC) begin
          state_nxt.misc = bus_i.wdata & ppo_pkg::MISC_WMASK;
        end else if (bus_i.addr == ppo_pkg::OFS_SENSE) begin
          state_nxt.sense = narrow(bus_i.wdata);
        end else if (bus_i.addr == ppo_pkg::OFS_IRQ_STAT) begin
          clr = narrow(bus_i.wdata);
        end else if (bus_i.addr == ppo_pkg::OFS_IRQ_MASK) begin
          state_nxt.mask = narrow(bus_i.wdata);
        end
      end
      // a new event wins over a same-cycle clear
      state_nxt.stat = (state_r.stat & ~clr) | edge_evt;

      state_nxt.rdata = ppo_pkg::RDATA_IDLE;
      if (bus_i.rd) begin
        if (bus_i.addr == ppo_pkg::OFS_DIR) begin
          state_nxt.rdata = widen(state_r.dir);
        end else if (bus_i.addr == ppo_pkg::OFS_LATCH) begin
          state_nxt.rdata = widen(state_r.latch);
        end else if (bus_i.addr == ppo_pkg::OFS_SAMPLE) begin
          state_nxt.rdata = widen(state_r.sample);
        end else if (bus_i.addr == ppo_pkg::OFS_MISC) begin
          state_nxt.rdata = state_r.misc;
        end else if (bus_i.addr == ppo_pkg::OFS_SENSE) begin
          state_nxt.rdata = widen(state_r.sense);
        end else if (bus_i.addr == ppo_pkg::OFS_IRQ_STAT) begin
          state_nxt.rdata = widen(state_r.stat);
        end else if (bus_i.addr == ppo_pkg::OFS_IRQ_MASK) begin
          state_nxt.rdata = widen(state_r.mask);
        end
      end

      state_nxt.oe = cell_oe;
      state_nxt.out = cell_out;
      state_nxt.pu = cell_pu;
      state_nxt.irq = |(state_nxt.stat & state_nxt.mask);
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r.dir <= ppo_pkg::DIR_RESET[WIDTH-1:0];
      state_r.latch <= ppo_pkg::LATCH_RESET[WIDTH-1:0];
      state_r.sync1 <= '0;
      state_r.sync2 <= '0;
      state_r.sync3 <= '0;
      state_r.sample <= '0;
      state_r.sense <= ppo_pkg::SENSE_RESET[WIDTH-1:0];
      state_r.stat <= '0;
      state_r.mask <= ppo_pkg::MASK_RESET[WIDTH-1:0];
      // pins tri-stated and pull-ups off from the moment reset rises
      state_r.oe <= '0;
      state_r.out <= '0;
      state_r.pu <= '0;
      state_r.misc <= ppo_pkg::MISC_RESET;
      state_r.rdata <= ppo_pkg::RDATA_IDLE;
      state_r.irq <= 1'b0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign rdata_o = state_r.rdata;
  assign pad_oe_o = state_r.oe;
  assign pad_out_o = state_r.out;
  assign pullup_en_o = state_r.pu;
  assign misc_function_control_o = state_r.misc;
  assign irq_o = state_r.irq;
  // taken before the synchroniser so clock-type users see no added delay
  assign raw_digital_input_o = cell_raw;
  // analog users see the bare pad level, never clamped or gated
  assign analog_pad_path_o = pad_i;

endmodule

// ### sim/ppo_far_model.sv
// far side: pad level resolution and peripheral override sources
`timescale 1ns/100ps
module ppo_far_model #(
  parameter int WIDTH = 8
) (
  input wire logic [WIDTH-1:0] ext_lvl_i,
  input wire logic [7:0] ovr_pat_i,
  input wire logic [WIDTH-1:0] pad_out_i,
  input wire logic [WIDTH-1:0] pad_oe_i,
  output logic [WIDTH-1:0] pad_o,
  output ppo_pkg::ppo_pin_ovr_t [WIDTH-1:0] ovr_o
);
  // undriven pins see a defined outside level, never a float
  assign pad_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ext_lvl_i);
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      ovr_o[i] = ovr_pat_i;
    end
  end
endmodule

// ### sim/ppo_port_monitor.sv
// concurrent checks on the ports of the port pin override block
`timescale 1ns/100ps
module ppo_port_monitor #(
  parameter int WIDTH = 8
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire ppo_pkg::ppo_bus_req_t bus_i,
  input wire logic [ppo_pkg::DATA_W-1:0] rdata_o,
  input wire logic sleep_clamp_i,
  input wire ppo_pkg::ppo_pin_ovr_t [WIDTH-1:0] ovr_i,
  input wire logic [WIDTH-1:0] pad_i,
  input wire logic [WIDTH-1:0] pad_out_o,
  input wire logic [WIDTH-1:0] pad_oe_o,
  input wire logic [WIDTH-1:0] pullup_en_o,
  input wire logic [WIDTH-1:0] raw_digital_input_o,
  input wire logic [WIDTH-1:0] analog_pad_path_o,
  input wire logic [ppo_pkg::DATA_W-1:0] misc_function_control_o,
  input wire logic irq_o
);
  sequence s_dir_ovr;
    ce_i && ovr_i[0].direction_override_enable;
  endsequence
  sequence s_pu_ovr;
    ce_i && ovr_i[0].pullup_override_enable;
  endsequence
  property p_rst_off;
    @(posedge core_clk_i) rst_i |-> !(|pullup_en_o) && !(|pad_oe_o);
  endproperty
  a_rst_off: assert property (p_rst_off) else $error("pull-up or driver on in reset");
  property p_pu_ovr;
    @(posedge core_clk_i) disable iff (rst_i)
      s_pu_ovr |=> pullup_en_o[0] == $past(ovr_i[0].pullup_override_value);
  endproperty
  a_pu_ovr: assert property (p_pu_ovr) else $error("pull-up ignores override");
  property p_pud;
    @(posedge core_clk_i) disable iff (rst_i)
      ce_i && !ovr_i[0].pullup_override_enable && misc_function_control_o[ppo_pkg::MISC_PUD_BIT]
      |=> !pullup_en_o[0];
  endproperty
  a_pud: assert property (p_pud) else $error("pull-up on while disabled");
  property p_dir_ovr;
    @(posedge core_clk_i) disable iff (rst_i)
      s_dir_ovr |=> pad_oe_o[0] == $past(ovr_i[0].direction_override_value);
  endproperty
  a_dir_ovr: assert property (p_dir_ovr) else $error("driver enable ignores override");
  property p_val_ovr;
    @(posedge core_clk_i) disable iff (rst_i)
      ce_i && ovr_i[0].out_value_override_enable |=> pad_out_o[0] == $past(ovr_i[0].out_value_override_value);
  endproperty
  a_val_ovr: assert property (p_val_ovr) else $error("driven value ignores override");
  property p_ie_ovr;
    @(posedge core_clk_i) ovr_i[0].input_enable_override_enable
      |-> raw_digital_input_o[0] == (pad_i[0] && ovr_i[0].input_enable_override_value);
  endproperty
  a_ie_ovr: assert property (p_ie_ovr) else $error("input enable ignores override");
  property p_awake;
    @(posedge core_clk_i) !sleep_clamp_i && !ovr_i[0].input_enable_override_enable
      |-> raw_digital_input_o[0] == pad_i[0];
  endproperty
  a_awake: assert property (p_awake) else $error("input gated while awake");
  property p_clamp_low;
    @(posedge core_clk_i) raw_digital_input_o[0] |-> pad_i[0];
  endproperty
  a_clamp_low: assert property (p_clamp_low) else $error("raw input high on low pad");
  property p_analog;
    @(posedge core_clk_i) analog_pad_path_o == pad_i;
  endproperty
  a_analog: assert property (p_analog) else $error("analog path differs from pad");
  property p_rsvd;
    @(posedge core_clk_i) disable iff (rst_i) !misc_function_control_o[ppo_pkg::MISC_RSVD_BIT];
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved misc bit set");
  property p_rdata;
    @(posedge core_clk_i) disable iff (rst_i) $past(ce_i) && rdata_o != 8'h00 |-> $past(bus_i.rd);
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data without read");
endmodule

bind ppo_port ppo_port_monitor #(.WIDTH(WIDTH)) mon_u (.core_clk_i(core_clk_i), .rst_i(rst_i),
  .ce_i(ce_i), .bus_i(bus_i), .rdata_o(rdata_o), .sleep_clamp_i(sleep_clamp_i), .ovr_i(ovr_i),
  .pad_i(pad_i), .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o), .pullup_en_o(pullup_en_o),
  .raw_digital_input_o(raw_digital_input_o), .analog_pad_path_o(analog_pad_path_o),
  .misc_function_control_o(misc_function_control_o), .irq_o(irq_o));

// ### sim/tb_top.sv
// self-checking bench for the port pin override block
`timescale 1ns/100ps
module tb_top;
  typedef struct packed {
    logic [7:0] dir, latch, misc, ovr, oe, out, pu;
  } ppo_row_t;
  logic core_clk_i = 1'b0;
  logic rst_i;
  logic ce_i = 1'b1;
  logic sleep_clamp_i = 1'b0;
  ppo_pkg::ppo_bus_req_t bus_i = '0;
  logic [7:0] ext_lvl = 8'h00;
  logic [7:0] ovr_pat = 8'h00;
  ppo_pkg::ppo_pin_ovr_t [7:0] ovr_i;
  logic [7:0] pad_i, pad_out_o, pad_oe_o, pullup_en_o, raw_o, misc_o, rdata_o;
  logic irq_o;
  int errors = 0;
  int checks_done = 0;
  ppo_row_t rows [7] = '{
    '{8'h0F, 8'h33, 8'h00, 8'h00, 8'h0F, 8'h33, 8'h30},
    '{8'h0F, 8'h33, 8'h04, 8'h00, 8'h0F, 8'h33, 8'h00},
    '{8'h0F, 8'h33, 8'h04, 8'hC0, 8'h0F, 8'h33, 8'hFF},
    '{8'h0F, 8'h33, 8'h00, 8'h80, 8'h0F, 8'h33, 8'h00},
    '{8'h0F, 8'h33, 8'h00, 8'h30, 8'hFF, 8'h33, 8'h30},
    '{8'h0F, 8'h33, 8'h00, 8'h2C, 8'h00, 8'hFF, 8'h30},
    '{8'h0F, 8'h33, 8'h00, 8'h08, 8'h0F, 8'h00, 8'h30}};
  ppo_port #(.WIDTH(8)) dut_u (.core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce_i), .bus_i(bus_i),
    .rdata_o(rdata_o), .sleep_clamp_i(sleep_clamp_i), .ovr_i(ovr_i), .pad_i(pad_i),
    .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o), .pullup_en_o(pullup_en_o),
    .raw_digital_input_o(raw_o), .analog_pad_path_o(), .misc_function_control_o(misc_o), .irq_o(irq_o));
  ppo_far_model #(.WIDTH(8)) far_u (.ext_lvl_i(ext_lvl), .ovr_pat_i(ovr_pat), .pad_out_i(pad_out_o),
    .pad_oe_i(pad_oe_o), .pad_o(pad_i), .ovr_o(ovr_i));
  always #12.5 core_clk_i = ~core_clk_i;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    bus_i <= '{a, d, 1'b1, 1'b0};
    @(posedge core_clk_i);
    bus_i <= '0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge core_clk_i);
    bus_i <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge core_clk_i);
    bus_i <= '0;
    #1 chk(rdata_o, exp);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge core_clk_i);
    errors++;
    final_report();
  end
  initial begin
    rst_i <= 1'b1;
    repeat (16) @(posedge core_clk_i);
    rst_i <= 1'b0;
    rd(ppo_pkg::OFS_MISC, ppo_pkg::MISC_RESET);
    wr(ppo_pkg::OFS_MISC, 8'hFF);
    rd(ppo_pkg::OFS_MISC, ppo_pkg::MISC_WMASK);
    chk(misc_o, 8'hEF);
    rd(3'h7, 8'h00);
    $display("register test done");
    foreach (rows[i]) begin
      wr(ppo_pkg::OFS_DIR, rows[i].dir);
      wr(ppo_pkg::OFS_LATCH, rows[i].latch);
      wr(ppo_pkg::OFS_MISC, rows[i].misc);
      ovr_pat <= rows[i].ovr;
      tick(2);
      chk(pad_oe_o, rows[i].oe);
      chk(pad_out_o, rows[i].out);
      chk(pullup_en_o, rows[i].pu);
    end
    $display("override table done");
    wr(ppo_pkg::OFS_DIR, 8'h00);
    ovr_pat <= 8'h00;
    wr(ppo_pkg::OFS_SENSE, 8'hFF);
    wr(ppo_pkg::OFS_IRQ_MASK, 8'h01);
    ext_lvl <= 8'hA5;
    tick(6);
    chk(raw_o, 8'hA5);
    rd(ppo_pkg::OFS_SAMPLE, 8'hA5);
    chk({7'h00, irq_o}, 8'h01);
    wr(ppo_pkg::OFS_IRQ_STAT, 8'hFF);
    tick(1);
    chk({7'h00, irq_o}, 8'h00);
    @(posedge core_clk_i);
    ext_lvl <= 8'hA7;
    tick(6);
    chk({7'h00, irq_o}, 8'h00);
    rd(ppo_pkg::OFS_IRQ_STAT, 8'h02);
    $display("interrupt test done");
    @(posedge core_clk_i);
    ext_lvl <= 8'hFF;
    tick(6);
    wr(ppo_pkg::OFS_IRQ_STAT, 8'hFF);
    sleep_clamp_i <= 1'b1;
    tick(3);
    chk(raw_o, 8'h01);
    @(posedge core_clk_i);
    ovr_pat <= 8'h03;
    #1 chk(raw_o, 8'hFF);
    @(posedge core_clk_i);
    ovr_pat <= 8'h00;
    tick(6);
    // the clamp itself gives the falling change; the one-cycle override pulse is filtered
    rd(ppo_pkg::OFS_IRQ_STAT, 8'hFE);
    wr(ppo_pkg::OFS_IRQ_STAT, 8'hFF);
    sleep_clamp_i <= 1'b0;
    tick(6);
    rd(ppo_pkg::OFS_IRQ_STAT, 8'hFE);
    chk({7'h00, irq_o}, 8'h00);
    $display("sleep test done");
    @(posedge core_clk_i);
    ce_i <= 1'b0;
    wr(ppo_pkg::OFS_DIR, 8'hFF);
    ce_i <= 1'b1;
    tick(2);
    chk(pad_oe_o, 8'h00);
    rd(ppo_pkg::OFS_DIR, 8'h00);
    wr(ppo_pkg::OFS_SAMPLE, 8'h00);
    rd(ppo_pkg::OFS_SAMPLE, 8'hFF);
    $display("enable test done");
    wr(ppo_pkg::OFS_LATCH, 8'hFF);
    tick(2);
    chk(pullup_en_o, 8'hFF);
    @(posedge core_clk_i);
    sleep_clamp_i <= 1'b1;
    rst_i <= 1'b1;
    tick(2);
    chk(pullup_en_o | pad_oe_o, 8'h00);
    chk(raw_o, 8'hFF);
    @(posedge core_clk_i);
    rst_i <= 1'b0;
    tick(2);
    chk(raw_o, 8'h00);
    chk(pullup_en_o, 8'h00);
    rd(ppo_pkg::OFS_LATCH, ppo_pkg::LATCH_RESET);
    $display("reset test done");
    final_report();
  end
endmodule
